// ===== sims_core.sv
/*
 * Split interrupt microframe status engine with APB register access.
 * Holds the upper descriptor words, issues start and complete splits
 * per microframe and records byte counts and result codes.
 * Assumes all inputs synchronous to clk; one result per issued split.
 */
`timescale 1ns/1ps
`include "sims_defines.svh"

module sims_core
   import sims_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire sims_tick_t tick,
   input wire sims_result_t result,
   output logic issueStartSplit,
   output logic issueCompleteSplit,
   output logic [2:0] issueSlot,
   output logic irq
);
   sims_state_t state_reg;
   sims_state_t state_next;
   sims_state_t base;

   logic [31:0] rdData;
   logic addrOk;
   logic wrEn;
   logic [7:0] slotSel;
   logic cntUpd;
   logic stUpd;
   logic [2:0] code;
   logic [63:0] countsNext;
   logic [23:0] statusNext;
   logic [2:0] irqSet;
   logic [2:0] irqClr;
   logic [2:0] irqStatNext;
   logic irqNext;
   logic takeResult;
   logic [7:0] ssEff;

   assign prdata = state_reg.prdata;
   assign pready = state_reg.pready;
   assign pslverr = state_reg.pslverr;
   assign issueStartSplit = state_reg.ssPulse;
   assign issueCompleteSplit = state_reg.csPulse;
   assign issueSlot = state_reg.curSlot;
   assign irq = state_reg.irq;

   // Write takes effect only at the completing access edge
   assign wrEn = psel && penable && state_reg.pready && pwrite && !state_reg.pslverr;

   // IN transfers may start splits only in slots 0 to 3
   assign ssEff = state_reg.dirIn ? {4'h0, state_reg.ssMask[3:0]} : state_reg.ssMask;

   always_comb begin
      addrOk = 1'b1;
      rdData = `SIMS_RST_WORD;
      case (paddr & 8'hfc)
         `SIMS_OFF_CTRL: begin
            rdData[`SIMS_CTRL_EN_BIT] = state_reg.enable;
            rdData[`SIMS_CTRL_DIRIN_BIT] = state_reg.dirIn;
            rdData[`SIMS_CTRL_FRAME_LSB +: 8] = state_reg.frameNo;
         end
         `SIMS_OFF_DW4: begin
            rdData = {state_reg.status, state_reg.ssMask};
         end
         `SIMS_OFF_DW5: begin
            rdData = {state_reg.counts[23:0], state_reg.csMask};
         end
         `SIMS_OFF_DW6: begin
            rdData = state_reg.counts[55:24];
         end
         `SIMS_OFF_DW7: begin
            rdData = {state_reg.dw7Rsvd, state_reg.counts[63:56]};
         end
         `SIMS_OFF_IRQ_STAT: begin
            rdData[`SIMS_IRQ_W-1:0] = state_reg.irqStat;
         end
         `SIMS_OFF_IRQ_MASK: begin
            rdData[`SIMS_IRQ_W-1:0] = state_reg.irqMask;
         end
         `SIMS_OFF_STATE: begin
            rdData[1:0] = state_reg.fsm;
            rdData[4:2] = state_reg.curSlot;
            rdData[5] = state_reg.frameOk;
            rdData[6] = state_reg.curIsCs;
         end
         default: begin
            addrOk = 1'b0;
         end
      endcase
   end

   // Result handling: decode the slot and build the result code
   always_comb begin
      takeResult = (state_reg.fsm == SIMS_WAIT) && result.valid && !tick.sof;
      // Slot n is mask bit n
      slotSel = 8'h01 << state_reg.curSlot;
      // Count needs start bit and matching frame
      cntUpd = takeResult && state_reg.ssMask[state_reg.curSlot] && state_reg.frameOk;
      stUpd = takeResult;
      code = 3'h0;
      // Babble only on IN, underrun only on OUT
      code[`SIMS_CODE_ERR_BIT] = result.err;
      code[`SIMS_CODE_BABBLE_BIT] = result.babble && state_reg.dirIn;
      code[`SIMS_CODE_UNDERRUN_BIT] = result.underrun && !state_reg.dirIn;
      irqClr = 3'h0;
      if (wrEn && ((paddr & 8'hfc) == `SIMS_OFF_IRQ_STAT)) begin
         irqClr = pwdata[`SIMS_IRQ_W-1:0];
      end
   end

   sims_slot_update u_slot (
      .counts(state_reg.counts),
      .status(state_reg.status),
      .slotSel(slotSel),
      .cntUpd(cntUpd),
      .stUpd(stUpd),
      .bytes(result.bytes),
      .code(code),
      .countsNext(countsNext),
      .statusNext(statusNext)
   );

   always_comb begin
      base = state_reg;
      base.ssPulse = 1'b0;
      base.csPulse = 1'b0;
      base.pready = 1'b0;
      base.pslverr = 1'b0;
      base.counts = countsNext;
      base.status = statusNext;
      irqSet = 3'h0;

      // Setup phase: answer in the following access cycle
      if (psel && !penable && !state_reg.pready) begin
         base.pready = 1'b1;
         base.pslverr = !addrOk;
         base.prdata = addrOk ? rdData : `SIMS_RST_WORD;
      end

      if (wrEn) begin
         case (paddr & 8'hfc)
            `SIMS_OFF_CTRL: begin
               base.enable = pwdata[`SIMS_CTRL_EN_BIT];
               base.dirIn = pwdata[`SIMS_CTRL_DIRIN_BIT];
               base.frameNo = pwdata[`SIMS_CTRL_FRAME_LSB +: 8];
            end
            `SIMS_OFF_DW4: begin
               base.ssMask = pwdata[7:0];
            end
            `SIMS_OFF_DW5: begin
               // Software arms complete-split slots
               base.csMask = pwdata[7:0];
            end
            `SIMS_OFF_DW7: begin
               // Stored as written, never used by hardware
               base.dw7Rsvd = pwdata[31:8];
            end
            `SIMS_OFF_IRQ_MASK: begin
               base.irqMask = pwdata[`SIMS_IRQ_W-1:0];
            end
            default: begin
            end
         endcase
      end

      case (state_reg.fsm)
         SIMS_IDLE: begin
         end
         SIMS_WAIT: begin
            if (takeResult) begin
               base.fsm = SIMS_IDLE;
               if (cntUpd) begin
                  irqSet[`SIMS_IRQ_COUNT_BIT] = 1'b1;
               end
               if (code != 3'h0) begin
                  irqSet[`SIMS_IRQ_ERROR_BIT] = 1'b1;
               end
               if (state_reg.curIsCs && result.isComplete) begin
                  // Processed slot goes back to zero
                  base.csMask[state_reg.curSlot] = 1'b0;
                  if ((base.csMask & ~slotSel) == 8'h00) begin
                     irqSet[`SIMS_IRQ_CSDONE_BIT] = 1'b1;
                  end
               end
            end
         end
         default: begin
            base.fsm = SIMS_IDLE;
         end
      endcase

      // Microframe start: pick a split for this slot; a pending one is dropped
      if (tick.sof) begin
         base.fsm = SIMS_IDLE;
         base.curSlot = tick.slot;
         base.frameOk = (tick.frameNum == state_reg.frameNo);
         base.curIsCs = 1'b0;
         if (state_reg.enable && (tick.frameNum == state_reg.frameNo)) begin
            if (ssEff[tick.slot]) begin
               // Start split in its marked slot
               base.ssPulse = 1'b1;
               base.fsm = SIMS_WAIT;
            end else if (state_reg.dirIn && base.csMask[tick.slot]) begin
               // Complete split only for IN, only in marked slots
               base.csPulse = 1'b1;
               base.curIsCs = 1'b1;
               base.fsm = SIMS_WAIT;
            end
         end
      end
   end

   sims_irq u_irq (
      .stat(state_reg.irqStat),
      .mask(base.irqMask),
      .set(irqSet),
      .clr(irqClr),
      .statNext(irqStatNext),
      .irqNext(irqNext)
   );

   always_comb begin
      state_next = base;
      state_next.irqStat = irqStatNext;
      state_next.irq = irqNext;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         state_reg <= '0;
         state_reg.fsm <= SIMS_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule

// ===== sims_core_chk.sv
/* Port assertions for sims_core.
   Assumes a bind onto sims_core; one clock, synchronous reset. */
`timescale 1ns/1ps
module sims_core_chk
   import sims_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic psel,
   input logic penable,
   input logic pwrite,
   input logic [7:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic pready,
   input logic pslverr,
   input sims_tick_t tick,
   input logic issueStartSplit,
   input logic issueCompleteSplit,
   input logic [2:0] issueSlot,
   input logic irq
);
   logic [15:0] ctrl_reg;
   logic anyIssue;
   assign anyIssue = issueStartSplit | issueCompleteSplit;
   // Control word as software last wrote it
   always_ff @(posedge clk) begin
      if (rst) begin
         ctrl_reg <= 16'h0000;
      end else if (psel && penable && pready && pwrite && paddr[7:2] == 6'h00) begin
         ctrl_reg <= pwdata[15:0];
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   setup_ready_a: assert property (psel && !penable |=> pready && penable)
      else $error("no pready after setup");
   ready_access_a: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   err_zero_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("bad error answer");
   reset_quiet_a: assert property ($fell(rst) |-> !irq && !anyIssue && !pready)
      else $error("outputs busy after reset");
   issue_slot_a: assert property (anyIssue |-> $past(tick.sof) && issueSlot == $past(tick.slot))
      else $error("issue not tied to slot");
   issue_frame_a: assert property (anyIssue |-> $past(tick.frameNum) == ctrl_reg[15:8])
      else $error("issue on wrong frame");
   split_excl_a: assert property (!(issueStartSplit && issueCompleteSplit))
      else $error("two splits at once");
   cs_in_only_a: assert property (issueCompleteSplit |-> ctrl_reg[1])
      else $error("complete split on out");
   ss_low_slot_a: assert property (issueStartSplit && ctrl_reg[1] |-> issueSlot < 3'd4)
      else $error("in start split above slot 3");
endmodule

bind sims_core sims_core_chk sims_core_chk_inst (.clk(clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .tick(tick), .issueStartSplit(issueStartSplit),
   .issueCompleteSplit(issueCompleteSplit), .issueSlot(issueSlot), .irq(irq));

// ===== sims_core_tb.sv
/* Self-checking bench for sims_core.
   Assumes sims_hub_model as far side and the bound checker. */
`timescale 1ns/1ps
module sims_core_tb
   import sims_pkg::*;
;
   logic clk = 1'b0;
   logic rst, psel, penable, pwrite, pready, pslverr, irq;
   logic issueStartSplit, issueCompleteSplit;
   logic [2:0] issueSlot, hubFlags;
   logic [7:0] paddr, hubBytes;
   logic [31:0] pwdata, prdata;
   sims_tick_t tick;
   sims_result_t result;
   int mismatches = 0;
   int nCompared = 0;
   int cycles = 0;
   always #2.5 clk = ~clk;
   sims_core sims_core_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .tick(tick), .result(result), .issueStartSplit(issueStartSplit),
      .issueCompleteSplit(issueCompleteSplit), .issueSlot(issueSlot), .irq(irq));
   sims_hub_model sims_hub_model_inst (.clk(clk), .rst(rst),
      .issueStartSplit(issueStartSplit), .issueCompleteSplit(issueCompleteSplit),
      .replyBytes(hubBytes), .replyFlags(hubFlags), .result(result));
   task automatic tally_and_finish;
      $display("compared %0d mismatches %0d", nCompared, mismatches);
      if (mismatches == 0 && nCompared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      nCompared++;
      if (seen !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
         output logic [31:0] rd, output logic er);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 32'h0000_0000, rd, er);
      check(what, rd, exp);
   endtask
   // Start of microframe, then the expected split pulses one cycle later
   task automatic sof(input logic [2:0] s, input logic [7:0] f, input logic ss, input logic cs);
      @(posedge clk);
      tick <= '{1'b1, s, f};
      @(posedge clk);
      tick <= '{1'b0, ~s, ~f};
      #1;
      check("start split", 32'(issueStartSplit), 32'(ss));
      check("complete split", 32'(issueCompleteSplit), 32'(cs));
      check("issue slot", 32'(issueSlot), 32'(s));
      repeat (8) @(posedge clk);
   endtask
   task automatic test_reset;
      logic [31:0] rd;
      logic er;
      rdchk("dw6", 8'h18, 32'h0000_0000);
      apb(1'b0, 8'h3c, 32'h0000_0000, rd, er);
      check("unmapped err", 32'(er), 32'h0000_0001);
      wr(8'h1c, 32'habcd_ef00);
      rdchk("dw7", 8'h1c, 32'habcd_ef00);
      wr(8'h24, 32'h0000_0007);
   endtask
   task automatic test_in_flow;
      wr(8'h00, 32'h0000_0503);
      rdchk("ctrl", 8'h00, 32'h0000_0503);
      wr(8'h10, 32'h0000_0011);
      wr(8'h14, 32'h0000_0004);
      hubBytes <= 8'h12;
      hubFlags <= 3'b000;
      sof(3'd0, 8'h05, 1'b1, 1'b0);
      sof(3'd4, 8'h05, 1'b0, 1'b0);
      hubBytes <= 8'h34;
      hubFlags <= 3'b111;
      sof(3'd2, 8'h05, 1'b0, 1'b1);
      check("irq", 32'(irq), 32'h0000_0001);
      rdchk("dw4", 8'h10, 32'h0000_c011);
      rdchk("dw5", 8'h14, 32'h0000_1200);
      rdchk("state", 8'h28, 32'h0000_0068);
      rdchk("irq stat", 8'h20, 32'h0000_0007);
      wr(8'h20, 32'h0000_0007);
      rdchk("irq stat", 8'h20, 32'h0000_0000);
      check("irq", 32'(irq), 32'h0000_0000);
   endtask
   task automatic test_frame_replace;
      sof(3'd0, 8'h06, 1'b0, 1'b0);
      hubBytes <= 8'h07;
      hubFlags <= 3'b000;
      sof(3'd0, 8'h05, 1'b1, 1'b0);
      rdchk("dw5", 8'h14, 32'h0000_0700);
   endtask
   task automatic test_out_flow;
      wr(8'h24, 32'h0000_0000);
      wr(8'h20, 32'h0000_0007);
      wr(8'h00, 32'h0000_0501);
      wr(8'h10, 32'h0000_c080);
      wr(8'h14, 32'h0000_0740);
      hubBytes <= 8'ha5;
      hubFlags <= 3'b111;
      sof(3'd6, 8'h05, 1'b0, 1'b0);
      sof(3'd7, 8'h05, 1'b1, 1'b0);
      rdchk("dw4", 8'h10, 32'ha000_c080);
      rdchk("dw5", 8'h14, 32'h0000_0740);
      rdchk("dw7", 8'h1c, 32'habcd_efa5);
      rdchk("irq stat", 8'h20, 32'h0000_0003);
      check("irq masked", 32'(irq), 32'h0000_0000);
   endtask
   // Reset in mid-run clears the descriptor words and the interrupt
   task automatic test_mid_reset;
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdchk("dw4 after reset", 8'h10, 32'h0000_0000);
      rdchk("dw7 after reset", 8'h1c, 32'h0000_0000);
      rdchk("irq stat after reset", 8'h20, 32'h0000_0000);
      check("irq after reset", 32'(irq), 32'h0000_0000);
   endtask
   initial begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      tick = '0;
      hubBytes = 8'h00;
      hubFlags = 3'b000;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      test_reset();
      test_in_flow();
      test_frame_replace();
      test_out_flow();
      test_mid_reset();
      tally_and_finish();
   end
endmodule

// ===== sims_defines.svh
/*
 * Register offsets, field positions and reset values of the split
 * interrupt microframe status block.
 * Assumes 32-bit APB data; byte address bits [1:0] are ignored.
 */
`ifndef SIMS_DEFINES_SVH
`define SIMS_DEFINES_SVH

`define SIMS_ADDR_W 8
`define SIMS_OFF_CTRL 8'h00
`define SIMS_OFF_DW4 8'h10
`define SIMS_OFF_DW5 8'h14
`define SIMS_OFF_DW6 8'h18
`define SIMS_OFF_DW7 8'h1c
`define SIMS_OFF_IRQ_STAT 8'h20
`define SIMS_OFF_IRQ_MASK 8'h24
`define SIMS_OFF_STATE 8'h28

`define SIMS_CTRL_EN_BIT 0
`define SIMS_CTRL_DIRIN_BIT 1
`define SIMS_CTRL_FRAME_LSB 8
`define SIMS_SLOTS 8
`define SIMS_IN_SS_SLOTS 4
`define SIMS_CODE_W 3
`define SIMS_CODE_ERR_BIT 0
`define SIMS_CODE_BABBLE_BIT 1
`define SIMS_CODE_UNDERRUN_BIT 2
`define SIMS_IRQ_W 3
`define SIMS_IRQ_COUNT_BIT 0
`define SIMS_IRQ_ERROR_BIT 1
`define SIMS_IRQ_CSDONE_BIT 2
`define SIMS_RST_WORD 32'h0000_0000

`endif

// ===== sims_hub_model.sv
/* Behavioural hub translator answering each issued split.
   Assumes the bench sets reply bytes and flags before each split. */
`timescale 1ns/1ps
module sims_hub_model
   import sims_pkg::*;
(
   input logic clk,
   input logic rst,
   input logic issueStartSplit,
   input logic issueCompleteSplit,
   input logic [7:0] replyBytes,
   input logic [2:0] replyFlags,
   output sims_result_t result
);
   logic [1:0] waitCnt_reg;
   logic csPend_reg;
   // Idle lines toggle so stale data never looks valid
   always @(posedge clk) begin
      if (rst) begin
         waitCnt_reg <= 2'd0;
         csPend_reg <= 1'b0;
         result <= '0;
      end else begin
         result <= {1'b0, ~result[11:0]};
         if (issueStartSplit || issueCompleteSplit) begin
            waitCnt_reg <= 2'd2;
            csPend_reg <= issueCompleteSplit;
         end else if (waitCnt_reg != 2'd0) begin
            waitCnt_reg <= waitCnt_reg - 2'd1;
            if (waitCnt_reg == 2'd1) begin
               result <= {1'b1, csPend_reg, replyBytes, replyFlags};
            end
         end
      end
   end
endmodule

// ===== sims_irq.sv
/*
 * Sticky interrupt status with write-one-to-clear and mask.
 * Combinational; a hardware set in the clearing cycle wins.
 */
`timescale 1ns/1ps
`include "sims_defines.svh"

module sims_irq
   import sims_pkg::*;
(
   input wire logic [2:0] stat,
   input wire logic [2:0] mask,
   input wire logic [2:0] set,
   input wire logic [2:0] clr,
   output logic [2:0] statNext,
   output logic irqNext
);
   assign statNext = (stat & ~clr) | set;
   assign irqNext = |(statNext & mask);
endmodule

// ===== sims_pkg.sv
/*
 * Types shared by the split interrupt microframe status block.
 * Assumes sims_defines.svh is on the include path.
 */
`include "sims_defines.svh"

package sims_pkg;

   typedef enum logic [1:0] {
      SIMS_IDLE = 2'b00,
      SIMS_WAIT = 2'b01
   } sims_fsm_t;

   // Outcome of one split transaction reported by the link engine
   typedef struct packed {
      logic valid;
      logic isComplete;
      logic [7:0] bytes;
      logic err;
      logic babble;
      logic underrun;
   } sims_result_t;

   // Microframe tick from the link engine
   typedef struct packed {
      logic sof;
      logic [2:0] slot;
      logic [7:0] frameNum;
   } sims_tick_t;

   typedef struct packed {
      sims_fsm_t fsm;
      logic enable;
      logic dirIn;
      logic [7:0] frameNo;
      logic [7:0] ssMask;
      logic [7:0] csMask;
      logic [23:0] status;
      logic [63:0] counts;
      logic [23:0] dw7Rsvd;
      logic [2:0] irqStat;
      logic [2:0] irqMask;
      logic [2:0] curSlot;
      logic frameOk;
      logic curIsCs;
      logic ssPulse;
      logic csPulse;
      logic irq;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } sims_state_t;

endpackage

// ===== sims_slot_update.sv
/*
 * Per-microframe byte count and result code update.
 * Purely combinational; the caller registers the outputs.
 */
`timescale 1ns/1ps
`include "sims_defines.svh"

module sims_slot_update
   import sims_pkg::*;
(
   input wire logic [63:0] counts,
   input wire logic [23:0] status,
   input wire logic [7:0] slotSel,
   input wire logic cntUpd,
   input wire logic stUpd,
   input wire logic [7:0] bytes,
   input wire logic [2:0] code,
   output logic [63:0] countsNext,
   output logic [23:0] statusNext
);
   genvar i;
   generate
      for (i = 0; i < `SIMS_SLOTS; i = i + 1) begin : g_slot
         // New count replaces the old one
         assign countsNext[8*i +: 8] = (cntUpd && slotSel[i]) ? bytes : counts[8*i +: 8];
         // Slot 7 lands in the top bits
         assign statusNext[3*i +: 3] = (stUpd && slotSel[i]) ? code : status[3*i +: 3];
      end
   endgenerate
endmodule
